// >>> board_pins.sv
// Board circuitry behind one shared port
`timescale 1ns/1ns
`default_nettype none
module board_pins (
	input wire logic [7:0] i_out,
	input wire logic [7:0] i_oe,
	input wire logic [7:0] i_board,
	output logic [7:0] o_pin
);
	// Board yields wherever the device drives
	assign o_pin = (i_oe & i_out) | (~i_oe & i_board);
endmodule
`default_nettype wire

// >>> pin_mux.v
// Pin function select, input source select, port registers and wake-up
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"

module pin_mux #(
	parameter W = 8
) (
	input wire i_mclk,
	input wire i_nrst,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	input wire i_sleep,
	input wire [W-1:0] i_pa,
	input wire [W-1:0] i_pb,
	input wire [W-1:0] i_pc,
	output wire [W-1:0] o_pa,
	output wire [W-1:0] o_pa_oe,
	output wire [W-1:0] o_pb,
	output wire [W-1:0] o_pb_oe,
	output wire [W-1:0] o_pc,
	output wire [W-1:0] o_pc_oe,
	input wire i_serial_chip_select_out,
	input wire i_serial_chip_select_oe,
	input wire i_lcd_common_segment_21,
	output wire o_external_interrupt_zero,
	output wire o_serial_chip_select,
	output wire [7:0] o_portd_function_select,
	output reg o_wake
);
	reg [7:0] port_c_upper_function_select;
	reg [7:0] port_d_lower_function_select;
	reg [7:0] input_source_select;
	reg [7:0] port_b_upper_function_select;
	reg [W-1:0] pa_data, pa_dir, pb_data, pb_dir, pc_data, pc_dir;
	reg [W-1:0] wake_en;
	reg [W-1:0] pa_prev;
	reg wake_flag;
	reg ack;
	wire [1:0] portc_bit6_function_field;
	wire [1:0] portb_bit5_function_field;
	wire port_c_bit_six, port_b_bit_five, port_b_bit_zero, port_a_bit_one;
	wire wr, rd;
	wire [3:0] reg_idx;
	wire [7:0] wbyte;
	wire [2:0] bit_sel;
	wire [1:0] bit_port;
	wire bit_val;
	wire [W-1:0] fall;

	// Single-cycle wait: each access answered the edge after it appears
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
	assign wr = i_avs_write & ~ack & i_avs_byteenable[0];
	assign rd = i_avs_read & ~ack;
	assign reg_idx = i_avs_address[5:2];
	assign wbyte = i_avs_writedata[7:0];
	assign bit_sel = wbyte[2:0];
	assign bit_val = wbyte[`BITOP_SET_BIT];
	assign bit_port = wbyte[`BITOP_PORT_LO+1:`BITOP_PORT_LO];

	assign portc_bit6_function_field =
		port_c_upper_function_select[`C6_SEL_LO+1:`C6_SEL_LO];
	assign portb_bit5_function_field =
		port_b_upper_function_select[`B5_SEL_LO+1:`B5_SEL_LO];
	assign port_c_bit_six = i_pc[6];
	assign port_b_bit_five = i_pb[5];
	assign port_b_bit_zero = i_pb[0];
	assign port_a_bit_one = i_pa[1];

	// Direction bit 1 = input, so the pin drives when the bit is 0
	function [1:0] pin_drive;
		input [1:0] field;
		input alt_code_is_01;
		input gpio_d;
		input gpio_dir;
		begin
			if (alt_code_is_01 ? field == `FN_PORT1 : field == `FN_ALT)
				pin_drive = {i_serial_chip_select_out,
					i_serial_chip_select_oe};
			else if (!alt_code_is_01 && field == `FN_LCD)
				pin_drive = {i_lcd_common_segment_21, 1'b1};
			else if (!alt_code_is_01 && field == `FN_PORT1)
				pin_drive = {gpio_d, ~gpio_dir};
			else if (field == `FN_PORT0)
				pin_drive = {gpio_d, ~gpio_dir};
			else
				pin_drive = 2'b00;
		end
	endfunction

	wire [1:0] c6_drv;
	wire [1:0] b5_drv;
	assign c6_drv = pin_drive(portc_bit6_function_field, 1'b0,
		pc_data[6], pc_dir[6]);
	assign b5_drv = pin_drive(portb_bit5_function_field, 1'b1,
		pb_data[5], pb_dir[5]);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : pins
			assign o_pa[g] = pa_data[g];
			assign o_pa_oe[g] = ~pa_dir[g];
			if (g == 5) begin : b5
				assign o_pb[g] = b5_drv[1];
				assign o_pb_oe[g] = b5_drv[0];
			end else begin : bn
				assign o_pb[g] = pb_data[g];
				assign o_pb_oe[g] = ~pb_dir[g];
			end
			if (g == 6) begin : c6
				assign o_pc[g] = c6_drv[1];
				assign o_pc_oe[g] = c6_drv[0];
			end else begin : cn
				assign o_pc[g] = pc_data[g];
				assign o_pc_oe[g] = ~pc_dir[g];
			end
		end
	endgenerate

	assign o_external_interrupt_zero =
		input_source_select[`SRC_IRQ0_BIT] ?
		port_a_bit_one : port_b_bit_zero;
	assign o_serial_chip_select =
		input_source_select[`SRC_CS_BIT] ?
		port_b_bit_five : port_c_bit_six;
	assign o_portd_function_select = port_d_lower_function_select;

	assign fall = pa_prev & ~i_pa & wake_en;

	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			port_c_upper_function_select <= `SEL_RESET;
			port_d_lower_function_select <= `SEL_RESET;
			input_source_select <= `SEL_RESET;
			port_b_upper_function_select <= `SEL_RESET;
			pa_data <= {W{1'b1}};
			pa_dir <= {W{1'b1}};
			pb_data <= {W{1'b1}};
			pb_dir <= {W{1'b1}};
			pc_data <= {W{1'b1}};
			pc_dir <= {W{1'b1}};
			wake_en <= {W{1'b0}};
			pa_prev <= {W{1'b1}};
			wake_flag <= 1'b0;
			o_wake <= 1'b0;
			ack <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= (i_avs_read | i_avs_write) & ~ack;
			pa_prev <= i_pa;
			o_wake <= i_sleep & (|fall);
			// Set wins over a software clear in the same cycle
			if (i_sleep & (|fall))
				wake_flag <= 1'b1;
			else if (wr && reg_idx == `REG_STATUS && wbyte[0])
				wake_flag <= 1'b0;
			if (wr) begin
				case (reg_idx)
				`REG_PORTC_SEL: port_c_upper_function_select <=
					wbyte & `SEL6_MASK;
				`REG_PORTD_SEL: port_d_lower_function_select <= wbyte;
				`REG_SRC_SEL: input_source_select <= wbyte & `SEL6_MASK;
				`REG_PORTB_SEL: port_b_upper_function_select <=
					wbyte & `SEL6_MASK;
				`REG_PORTA_DATA: pa_data <= wbyte[W-1:0];
				`REG_PORTA_DIR: pa_dir <= wbyte[W-1:0];
				`REG_PORTB_DATA: pb_data <= wbyte[W-1:0];
				`REG_PORTB_DIR: pb_dir <= wbyte[W-1:0];
				`REG_PORTC_DATA: pc_data <= wbyte[W-1:0];
				`REG_PORTC_DIR: pc_dir <= wbyte[W-1:0];
				`REG_WAKE_EN: wake_en <= wbyte[W-1:0];
				// Whole port read, one bit changed, byte written back
				`REG_BITOP: begin
					case (bit_port)
					2'h0: begin
						pa_data <= i_pa;
						pa_data[bit_sel] <= bit_val;
					end
					2'h1: begin
						pb_data <= i_pb;
						pb_data[bit_sel] <= bit_val;
					end
					2'h2: begin
						pc_data <= i_pc;
						pc_data[bit_sel] <= bit_val;
					end
					default: ;
					endcase
				end
				default: ;
				endcase
			end
			if (rd) begin
				case (reg_idx)
				`REG_PORTC_SEL: o_avs_readdata <=
					{24'h0, port_c_upper_function_select};
				`REG_PORTD_SEL: o_avs_readdata <=
					{24'h0, port_d_lower_function_select};
				`REG_SRC_SEL: o_avs_readdata <= {24'h0, input_source_select};
				`REG_PORTB_SEL: o_avs_readdata <=
					{24'h0, port_b_upper_function_select};
				`REG_PORTA_DATA: o_avs_readdata <= {24'h0, pa_data};
				`REG_PORTA_DIR: o_avs_readdata <= {24'h0, pa_dir};
				`REG_PORTB_DATA: o_avs_readdata <= {24'h0, pb_data};
				`REG_PORTB_DIR: o_avs_readdata <= {24'h0, pb_dir};
				`REG_PORTC_DATA: o_avs_readdata <= {24'h0, pc_data};
				`REG_PORTC_DIR: o_avs_readdata <= {24'h0, pc_dir};
				`REG_WAKE_EN: o_avs_readdata <= {24'h0, wake_en};
				`REG_STATUS: o_avs_readdata <= {31'h0, wake_flag};
				`REG_PINS_A: o_avs_readdata <= {24'h0, i_pa};
				`REG_PINS_B: o_avs_readdata <= {24'h0, i_pb};
				`REG_PINS_C: o_avs_readdata <= {24'h0, i_pc};
				default: o_avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> pin_mux_chk.sv
// Port checker for the pin mux
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"
module pin_mux_chk #(parameter W = 8) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_sleep,
	input wire logic [W-1:0] i_pa,
	input wire logic [W-1:0] i_pb,
	input wire logic [W-1:0] i_pc,
	input wire logic [W-1:0] o_pa,
	input wire logic [W-1:0] o_pa_oe,
	input wire logic o_external_interrupt_zero,
	input wire logic o_serial_chip_select,
	input wire logic o_wake
);
	logic [7:0] src;
	wire req = i_avs_read | i_avs_write;
	wire sel = i_avs_address[5:2] == `REG_SRC_SEL;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	// Lags the design by a cycle, so routing is judged between writes
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst)
			src <= 8'h00;
		else if (i_avs_write && !o_avs_waitrequest && sel)
			src <= i_avs_writedata[7:0];
	end
	wait_one_a: assert property (req && !$past(req) |->
		o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bad wait");
	data_upper_a: assert property (i_avs_read && !o_avs_waitrequest |->
		o_avs_readdata[31:8] == 24'h0 &&
		(i_avs_address[5:2] == `REG_PORTD_SEL ||
		i_avs_address[5:2] > `REG_PORTB_SEL ||
		o_avs_readdata[7:6] == 2'h0)) else $error("upper bits set");
	rst_out_a: assert property ($rose(i_nrst) |-> &o_pa)
		else $error("port not high");
	rst_oe_a: assert property ($rose(i_nrst) |-> o_pa_oe == 8'h00)
		else $error("pin driven");
	irq_route_a: assert property (!i_avs_write |->
		o_external_interrupt_zero == (src[4] ? i_pa[1] : i_pb[0]))
		else $error("irq0 source");
	cs_route_a: assert property (!i_avs_write |->
		o_serial_chip_select == (src[1] ? i_pb[5] : i_pc[6]))
		else $error("chip select source");
	wake_pulse_a: assert property (o_wake |=> !o_wake)
		else $error("wake too long");
	wake_asleep_a: assert property (o_wake |-> $past(i_sleep))
		else $error("wake while awake");
	cover property (o_wake);
	cover property (i_avs_write && !o_avs_waitrequest && sel);
	cover property (src[4] && src[1]);
endmodule
bind pin_mux pin_mux_chk #(.W(W)) u_chk (.i_mclk, .i_nrst, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
	.o_avs_waitrequest, .i_sleep, .i_pa, .i_pb, .i_pc, .o_pa, .o_pa_oe,
	.o_external_interrupt_zero, .o_serial_chip_select, .o_wake);
`default_nettype wire

// >>> pin_mux_consts.vh
// Register offsets, field positions, reset values and codes for the pin mux
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

`define REG_PORTC_SEL 4'h0
`define REG_PORTD_SEL 4'h1
`define REG_SRC_SEL 4'h2
`define REG_PORTB_SEL 4'h3
`define REG_PORTA_DATA 4'h4
`define REG_PORTA_DIR 4'h5
`define REG_PORTB_DATA 4'h6
`define REG_PORTB_DIR 4'h7
`define REG_PORTC_DATA 4'h8
`define REG_PORTC_DIR 4'h9
`define REG_WAKE_EN 4'ha
`define REG_BITOP 4'hb
`define REG_STATUS 4'hc
`define REG_PINS_A 4'hd
`define REG_PINS_B 4'he
`define REG_PINS_C 4'hf

`define SEL_RESET 8'h00
`define PORT_RESET 8'hff
`define SEL6_MASK 8'h3f

`define C6_SEL_LO 4
`define B5_SEL_LO 2
`define SRC_IRQ0_BIT 4
`define SRC_CS_BIT 1

`define FN_PORT0 2'h0
`define FN_PORT1 2'h1
`define FN_ALT 2'h2
`define FN_LCD 2'h3

`define BITOP_SET_BIT 3
`define BITOP_PORT_LO 4

`endif

// >>> tb.sv
// Self-checking bench for the pin mux
`timescale 1ns/1ns
`default_nettype none
`include "pin_mux_consts.vh"
module tb;
	logic i_mclk, i_nrst, i_avs_read, i_avs_write, i_sleep, cs_o, cs_e, lcd;
	logic [5:0] i_avs_address;
	logic [31:0] i_avs_writedata, rd;
	logic [23:0] bd;
	logic [7:0] ex;
	logic [7:0] mreg [16];
	wire [7:0] i_pa, i_pb, i_pc, o_pa, o_pb, o_pc, o_pa_oe, o_pb_oe, o_pc_oe;
	wire [7:0] o_portd_function_select;
	wire [31:0] o_avs_readdata;
	wire o_avs_waitrequest, o_external_interrupt_zero, o_serial_chip_select;
	wire o_wake;
	integer miscompares = 0, check_count = 0, wakes = 0, k, seed;
	pin_mux i_dut (.i_mclk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .i_avs_byteenable(4'hf), .o_avs_readdata,
		.o_avs_waitrequest, .i_sleep, .i_pa, .i_pb, .i_pc, .o_pa, .o_pa_oe,
		.o_pb, .o_pb_oe, .o_pc, .o_pc_oe, .i_serial_chip_select_out(cs_o),
		.i_serial_chip_select_oe(cs_e), .i_lcd_common_segment_21(lcd),
		.o_external_interrupt_zero, .o_serial_chip_select,
		.o_portd_function_select, .o_wake);
	board_pins b_a (.i_out(o_pa), .i_oe(o_pa_oe), .i_board(bd[7:0]),
		.o_pin(i_pa));
	board_pins b_b (.i_out(o_pb), .i_oe(o_pb_oe), .i_board(bd[15:8]),
		.o_pin(i_pb));
	board_pins b_c (.i_out(o_pc), .i_oe(o_pc_oe), .i_board(bd[23:16]),
		.o_pin(i_pc));
	initial begin
		i_mclk = 0;
		forever #10 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) if (o_wake === 1'b1) wakes <= wakes + 1;
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		check_count = check_count + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Only the watchdog ends a wait that never gets its answer
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_avs_address <= {a, 2'b00};
		i_avs_writedata <= {24'h0, d};
		i_avs_write <= w;
		i_avs_read <= !w;
		do
			@(posedge i_mclk);
		while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_write <= 0;
		i_avs_read <= 0;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1, a, d);
		// Reserved top bits of three select registers never store
		mreg[a] = d & ((a == 0 || a == 2 || a == 3) ? 8'h3f : 8'hff);
	endtask
	task rdm(input logic [3:0] a);
		bus(0, a, 8'h00);
		chk(rd, {24'h0, mreg[a]}, "register");
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares = miscompares + 1;
		wrap_up;
	end
	initial begin
		seed = 32'hc10d0392;
		{i_nrst, i_avs_read, i_avs_write, i_sleep, cs_o, cs_e, lcd} = 0;
		i_avs_address = 0;
		i_avs_writedata = 0;
		bd = 24'hffffff;
		for (k = 0; k < 16; k++) mreg[k] = (k > 3 && k < 10) ? 8'hff : 8'h00;
		repeat (6) @(posedge i_mclk);
		i_nrst <= 1;
		for (k = 0; k < 13; k++) rdm(k[3:0]);
		wr(`REG_PORTA_DIR, 8'h00);
		chk({o_pa_oe, o_pa}, 16'hffff, "pa drive");
		wr(`REG_PORTA_DIR, 8'hff);
		for (k = 0; k < 4; k++) begin
			bd <= 24'($random(seed));
			wr(`REG_SRC_SEL, {3'h0, k[1], 2'h0, k[0], 1'b0});
			chk(o_external_interrupt_zero, k[1] ? bd[1] : bd[8], "irq0");
			chk(o_serial_chip_select, k[0] ? bd[13] : bd[22], "cs in");
		end
		for (k = 0; k < 4; k++) begin
			wr(k[3:0], 8'hff);
			rdm(k[3:0]);
		end
		chk(o_portd_function_select, 8'hff, "portd select");
		wr(`REG_PORTC_DIR, 8'hbf);
		for (k = 0; k < 4; k++) begin
			{cs_o, cs_e, lcd} <= 3'($random(seed));
			wr(`REG_PORTC_SEL, {2'h0, k[1:0], 4'h0});
			chk({o_pc_oe[6], o_pc[6]}, k < 2 ? 2'b11 : k == 2 ? {cs_e, cs_o}
				: {1'b1, lcd}, "c6 drive");
		end
		wr(`REG_PORTB_SEL, 8'h04);
		chk({o_pb_oe[5], o_pb[5]}, {cs_e, cs_o}, "b5 drive");
		// Ports A, B, C in turn; expected byte is the pins as they stand with bit k*3 inverted
		for (k = 0; k < 3; k++) begin
			bd <= 24'($random(seed));
			repeat (2) @(posedge i_mclk);
			ex = k == 0 ? i_pa : k == 1 ? i_pb : i_pc;
			ex[k * 3] = !ex[k * 3];
			bus(1, `REG_BITOP, {2'h0, k[1:0], ex[k * 3], 3'(k * 3)});
			mreg[`REG_PORTA_DATA + 2 * k] = ex;
			rdm(4'(`REG_PORTA_DATA + 2 * k));
		end
		wr(`REG_WAKE_EN, 8'h02);
		bd <= 24'hffffff;
		i_sleep <= 1;
		repeat (3) @(posedge i_mclk);
		bd[7:0] <= 8'hfe;
		repeat (4) @(posedge i_mclk);
		chk(wakes, 0, "masked wake");
		bd[7:0] <= 8'hfc;
		repeat (4) @(posedge i_mclk);
		chk(wakes, 1, "wake");
		mreg[`REG_STATUS] = 8'h01;
		rdm(`REG_STATUS);
		i_sleep <= 0;
		wr(`REG_STATUS, 8'h01);
		mreg[`REG_STATUS] = 8'h00;
		rdm(`REG_STATUS);
		wrap_up;
	end
endmodule
`default_nettype wire
